// File: hdl/rtc_core.sv
// real-time clock with step, load, read and rate correction
// Summary of operation
// - three-bit phase names 5 ns sub-slot
// - nanoseconds as two 16-bit words, reset zero
// - seconds as two 16-bit words, reset zero
// - 30-bit fractional rate split over two words
// - one rate value serves both corrections
// - direction one adds rate per tick
// - direction zero subtracts rate per tick
// - temporary bit corrects for programmed duration
// - clearing temporary bit stops the correction
// - 32-bit duration in base ticks, two words
// - read command copies live time to holds
// - load command sets live time from holds
// - step command adds or subtracts held time
// - continuous enable corrects every base tick
`timescale 1ns/100ps
module rtc_core (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [rtc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rtc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rtc_pkg::DATA_W-1:0] o_rdata,
  // live time for the rest of the switch
  output logic [31:0] o_live_sec,
  output logic [31:0] o_live_ns,
  output logic [rtc_pkg::PHASE_W-1:0] o_live_phase
);
  logic tick;

  // control state
  logic enable;
  logic cont_on;
  logic step_dir;
  logic rate_dir;
  logic temp_on;
  logic [rtc_pkg::RATE_W-1:0] rate;
  logic [31:0] tdur;
  // held (software-visible) time
  logic [rtc_pkg::PHASE_W-1:0] hold_phase;
  logic [31:0] hold_ns;
  logic [31:0] hold_sec;
  // live time and fractional accumulator
  logic [rtc_pkg::RATE_W-1:0] frac;

  logic next_enable;
  logic next_cont_on;
  logic next_step_dir;
  logic next_rate_dir;
  logic next_temp_on;
  logic [rtc_pkg::RATE_W-1:0] next_rate;
  logic [31:0] next_tdur;
  logic [rtc_pkg::PHASE_W-1:0] next_hold_phase;
  logic [31:0] next_hold_ns;
  logic [31:0] next_hold_sec;
  logic [rtc_pkg::RATE_W-1:0] next_frac;
  logic [31:0] next_live_ns;
  logic [31:0] next_live_sec;
  logic [rtc_pkg::PHASE_W-1:0] next_live_phase;
  logic [rtc_pkg::DATA_W-1:0] next_rdata;

  // base tick source
  rtc_tick_gen u_tick (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  // decoded writes
  logic wr_ctrl;
  logic cmd_reset;
  logic cmd_load;
  logic cmd_read;
  logic cmd_step;

  always_comb begin
    wr_ctrl = i_wr && (i_addr == rtc_pkg::OFF_CTRL);
    cmd_reset = wr_ctrl && i_wdata[rtc_pkg::CTRL_RESET_BIT];
    cmd_load = wr_ctrl && i_wdata[rtc_pkg::CTRL_LOAD_BIT];
    cmd_read = wr_ctrl && i_wdata[rtc_pkg::CTRL_READ_BIT];
    cmd_step = wr_ctrl && i_wdata[rtc_pkg::CTRL_STEP_BIT];
  end

  // correction arithmetic on the fractional accumulator
  logic corr_active;
  logic [rtc_pkg::RATE_W:0] frac_sum;
  logic [rtc_pkg::RATE_W:0] frac_diff;
  logic [31:0] tick_inc;
  logic [32:0] tick_ns;

  always_comb begin
    corr_active = cont_on || (temp_on && (tdur != 32'h0000_0000));
    frac_sum = {1'b0, frac} + {1'b0, rate};
    frac_diff = {1'b0, frac} - {1'b0, rate};
    tick_inc = rtc_pkg::NS_PER_TICK;
    if (corr_active && rate_dir) begin
      tick_inc = rtc_pkg::NS_PER_TICK + {31'h0, frac_sum[rtc_pkg::RATE_W]};
    end else if (corr_active) begin
      tick_inc = rtc_pkg::NS_PER_TICK - {31'h0, frac_diff[rtc_pkg::RATE_W]};
    end
    tick_ns = {1'b0, o_live_ns} + {1'b0, tick_inc};
  end

  // step arithmetic, add or subtract held time
  logic [32:0] step_ns_add;
  logic [32:0] step_ns_sub;
  logic [31:0] step_ns;
  logic [31:0] step_sec;

  always_comb begin
    step_ns_add = {1'b0, o_live_ns} + {1'b0, hold_ns};
    step_ns_sub = {1'b0, o_live_ns} - {1'b0, hold_ns};
    // direction from this write
    // the bit written beside the step must steer that same step
    if (i_wdata[rtc_pkg::CTRL_STEP_DIR_BIT]) begin
      if (step_ns_add >= rtc_pkg::NS_PER_SEC) begin
        step_ns = 32'(step_ns_add - rtc_pkg::NS_PER_SEC);
        step_sec = o_live_sec + hold_sec + 32'h0000_0001;
      end else begin
        step_ns = step_ns_add[31:0];
        step_sec = o_live_sec + hold_sec;
      end
    end else begin
      if (step_ns_sub[32]) begin
        step_ns = 32'(step_ns_sub + rtc_pkg::NS_PER_SEC);
        step_sec = o_live_sec - hold_sec - 32'h0000_0001;
      end else begin
        step_ns = step_ns_sub[31:0];
        step_sec = o_live_sec - hold_sec;
      end
    end
  end

  // live time: reset beats load beats step beats tick
  always_comb begin
    next_live_ns = o_live_ns;
    next_live_sec = o_live_sec;
    next_live_phase = o_live_phase;
    next_frac = frac;
    if (cmd_reset) begin
      next_live_ns = '0;
      next_live_sec = '0;
      next_live_phase = '0;
      next_frac = '0;
    end else if (cmd_load) begin
      next_live_ns = hold_ns;
      next_live_sec = hold_sec;
      next_live_phase = hold_phase;
    end else if (cmd_step) begin
      next_live_ns = step_ns;
      next_live_sec = step_sec;
    end else if (tick && enable) begin
      if (corr_active) begin
        next_frac = rate_dir ? frac_sum[rtc_pkg::RATE_W-1:0] :
          frac_diff[rtc_pkg::RATE_W-1:0];
      end
      if (tick_ns >= rtc_pkg::NS_PER_SEC) begin
        next_live_ns = 32'(tick_ns - rtc_pkg::NS_PER_SEC);
        next_live_sec = o_live_sec + 32'h0000_0001;
      end else begin
        next_live_ns = tick_ns[31:0];
      end
    end
  end

  // software registers, holds and the duration countdown
  always_comb begin
    next_enable = enable;
    next_cont_on = cont_on;
    next_step_dir = step_dir;
    next_rate_dir = rate_dir;
    next_temp_on = temp_on;
    next_rate = rate;
    next_tdur = tdur;
    next_hold_phase = hold_phase;
    next_hold_ns = hold_ns;
    next_hold_sec = hold_sec;
    // countdown per tick, clear at zero
    if (tick && enable && temp_on) begin
      if (tdur == 32'h0000_0000) begin
        next_temp_on = 1'b0;
      end else begin
        next_tdur = tdur - 32'h0000_0001;
        if (tdur == 32'h0000_0001) begin
          next_temp_on = 1'b0;
        end
      end
    end
    if (wr_ctrl) begin
      next_enable = i_wdata[rtc_pkg::CTRL_ENABLE_BIT];
      next_cont_on = i_wdata[rtc_pkg::CTRL_CONT_BIT];
      next_step_dir = i_wdata[rtc_pkg::CTRL_STEP_DIR_BIT];
    end
    if (cmd_read) begin
      next_hold_phase = o_live_phase;
      next_hold_ns = o_live_ns;
      next_hold_sec = o_live_sec;
    end
    if (i_wr) begin
      case (i_addr)
        rtc_pkg::OFF_PHASE: next_hold_phase = i_wdata[rtc_pkg::PHASE_W-1:0];
        rtc_pkg::OFF_NS_HI: next_hold_ns[31:16] = i_wdata;
        rtc_pkg::OFF_NS_LO: next_hold_ns[15:0] = i_wdata;
        rtc_pkg::OFF_SEC_HI: next_hold_sec[31:16] = i_wdata;
        rtc_pkg::OFF_SEC_LO: next_hold_sec[15:0] = i_wdata;
        rtc_pkg::OFF_RATE_HI: begin
          next_rate[rtc_pkg::RATE_W-1:16] = i_wdata[rtc_pkg::RATE_HI_W-1:0];
          next_rate_dir = i_wdata[rtc_pkg::RATE_DIR_BIT];
          next_temp_on = i_wdata[rtc_pkg::RATE_TEMP_BIT];
        end
        rtc_pkg::OFF_RATE_LO: next_rate[15:0] = i_wdata;
        rtc_pkg::OFF_TDUR_HI: next_tdur[31:16] = i_wdata;
        rtc_pkg::OFF_TDUR_LO: next_tdur[15:0] = i_wdata;
        default: begin
        end
      endcase
    end
  end

  // read mux, unmapped addresses and command bits read zero
  always_comb begin
    next_rdata = rtc_pkg::RESET_WORD;
    if (i_rd) begin
      case (i_addr)
        rtc_pkg::OFF_CTRL: begin
          next_rdata[rtc_pkg::CTRL_ENABLE_BIT] = enable;
          next_rdata[rtc_pkg::CTRL_CONT_BIT] = cont_on;
          next_rdata[rtc_pkg::CTRL_STEP_DIR_BIT] = step_dir;
        end
        rtc_pkg::OFF_PHASE: next_rdata[rtc_pkg::PHASE_W-1:0] = hold_phase;
        rtc_pkg::OFF_NS_HI: next_rdata = hold_ns[31:16];
        rtc_pkg::OFF_NS_LO: next_rdata = hold_ns[15:0];
        rtc_pkg::OFF_SEC_HI: next_rdata = hold_sec[31:16];
        rtc_pkg::OFF_SEC_LO: next_rdata = hold_sec[15:0];
        rtc_pkg::OFF_RATE_HI: begin
          next_rdata[rtc_pkg::RATE_HI_W-1:0] = rate[rtc_pkg::RATE_W-1:16];
          next_rdata[rtc_pkg::RATE_DIR_BIT] = rate_dir;
          next_rdata[rtc_pkg::RATE_TEMP_BIT] = temp_on;
        end
        rtc_pkg::OFF_RATE_LO: next_rdata = rate[15:0];
        rtc_pkg::OFF_TDUR_HI: next_rdata = tdur[31:16];
        rtc_pkg::OFF_TDUR_LO: next_rdata = tdur[15:0];
        default: next_rdata = rtc_pkg::RESET_WORD;
      endcase
    end
  end

  // state registers
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      enable <= 1'b0;
      cont_on <= 1'b0;
      step_dir <= 1'b0;
      rate_dir <= 1'b0;
      temp_on <= 1'b0;
      rate <= '0;
      tdur <= '0;
      hold_phase <= '0;
      hold_ns <= '0;
      hold_sec <= '0;
      frac <= '0;
      o_live_ns <= '0;
      o_live_sec <= '0;
      o_live_phase <= '0;
      o_rdata <= rtc_pkg::RESET_WORD;
    end else begin
      enable <= next_enable;
      cont_on <= next_cont_on;
      step_dir <= next_step_dir;
      rate_dir <= next_rate_dir;
      temp_on <= next_temp_on;
      rate <= next_rate;
      tdur <= next_tdur;
      hold_phase <= next_hold_phase;
      hold_ns <= next_hold_ns;
      hold_sec <= next_hold_sec;
      frac <= next_frac;
      o_live_ns <= next_live_ns;
      o_live_sec <= next_live_sec;
      o_live_phase <= next_live_phase;
      o_rdata <= next_rdata;
    end
  end
endmodule : rtc_core

// File: hdl/rtc_pkg.sv
// constants for the precision-time real-time clock block
package rtc_pkg;
  // bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // register byte offsets
  localparam logic [15:0] OFF_CTRL = 16'h0500;
  localparam logic [15:0] OFF_PHASE = 16'h0502;
  localparam logic [15:0] OFF_NS_HI = 16'h0504;
  localparam logic [15:0] OFF_NS_LO = 16'h0506;
  localparam logic [15:0] OFF_SEC_HI = 16'h0508;
  localparam logic [15:0] OFF_SEC_LO = 16'h050A;
  localparam logic [15:0] OFF_RATE_HI = 16'h050C;
  localparam logic [15:0] OFF_RATE_LO = 16'h050E;
  localparam logic [15:0] OFF_TDUR_HI = 16'h0510;
  localparam logic [15:0] OFF_TDUR_LO = 16'h0512;

  // control register bit positions
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_ENABLE_BIT = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int CTRL_LOAD_BIT = 3;
  localparam int CTRL_READ_BIT = 4;
  localparam int CTRL_STEP_DIR_BIT = 5;
  localparam int CTRL_STEP_BIT = 6;

  // rate upper word layout
  localparam int RATE_DIR_BIT = 15;
  localparam int RATE_TEMP_BIT = 14;
  localparam int RATE_HI_W = 14;
  localparam int RATE_W = 30;

  // field widths and reset values
  localparam int PHASE_W = 3;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // time constants
  localparam int CLK_PERIOD_NS = 5;
  localparam int BASE_PERIOD_NS = 40;
  localparam int TICK_DIV = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 3;
  localparam logic [31:0] NS_PER_TICK = 32'h0000_0028;
  localparam logic [32:0] NS_PER_SEC = 33'h0_3B9A_CA00;
endpackage : rtc_pkg

// File: hdl/rtc_tick_gen.sv
// divider making the 25 MHz base tick from the 200 MHz clock
`timescale 1ns/100ps
module rtc_tick_gen (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // one-cycle pulse every base period
  output logic o_tick
);
  localparam logic [rtc_pkg::TICK_CNT_W-1:0] LAST =
    rtc_pkg::TICK_CNT_W'(rtc_pkg::TICK_DIV - 1);

  logic [rtc_pkg::TICK_CNT_W-1:0] cnt;
  logic [rtc_pkg::TICK_CNT_W-1:0] next_cnt;
  logic next_tick;

  // free-running count, pulse on the last slot
  always_comb begin
    next_tick = (cnt == LAST);
    next_cnt = next_tick ? '0 : cnt + 1'b1;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule : rtc_tick_gen

// File: tb/rtc_core_assertions.sv
// checker for the rtc register port and live time outputs
`timescale 1ns/100ps
module rtc_core_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [rtc_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rtc_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [rtc_pkg::DATA_W-1:0] o_rdata,
  // live time
  input wire logic [31:0] o_live_sec,
  input wire logic [31:0] o_live_ns,
  input wire logic [rtc_pkg::PHASE_W-1:0] o_live_phase
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic ctl_d;
  // a control write one edge back excuses any jump of live time
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_d <= 1'b0;
    end else begin
      ctl_d <= i_wr && i_addr == rtc_pkg::OFF_CTRL;
    end
  end
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
    else $error("read data not zero outside read slot");
  rd_unmapped_a: assert property ($past(i_rd) && $past(i_addr) == 16'h0600
    |-> o_rdata == 16'h0000) else $error("unmapped read not zero");
  phase_reserved_a: assert property ($past(i_rd) &&
    $past(i_addr) == rtc_pkg::OFF_PHASE |-> o_rdata[15:3] == 13'h0000)
    else $error("phase reserved bits not zero");
  phase_hold_a: assert property ($changed(o_live_phase) |-> ctl_d)
    else $error("phase moved without a control write");
  ns_range_a: assert property (o_live_ns < 32'h3B9A_CA00)
    else $error("live ns at or past one second");
  ns_step_a: assert property ($changed(o_live_ns) && !ctl_d &&
    o_live_ns > $past(o_live_ns) |->
    (o_live_ns - $past(o_live_ns)) inside {32'h27, 32'h28, 32'h29})
    else $error("tick step not 40 ns plus or minus one");
  ns_wrap_a: assert property ($changed(o_live_ns) && !ctl_d &&
    o_live_ns < $past(o_live_ns) |->
    o_live_sec == $past(o_live_sec) + 32'h1 && o_live_ns < 32'h29)
    else $error("ns wrap without seconds carry");
  sec_cause_a: assert property ($changed(o_live_sec) |-> ctl_d ||
    o_live_ns < $past(o_live_ns)) else $error("seconds moved alone");
  tick_gap_a: assert property ($changed(o_live_ns) && !ctl_d
    |=> ($stable(o_live_ns) || ctl_d) [*7])
    else $error("live ns moved twice within one base period");
  // main scenarios
  wrap_c: cover property (o_live_sec == $past(o_live_sec) + 32'h1);
  fast_c: cover property (o_live_ns == $past(o_live_ns) + 32'h29);
  slow_c: cover property (o_live_ns == $past(o_live_ns) + 32'h27);
endmodule : rtc_core_chk

bind rtc_core rtc_core_chk rtc_core_chk_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_live_sec(o_live_sec), .o_live_ns(o_live_ns),
  .o_live_phase(o_live_phase));

// File: tb/tb.sv
// self-checking bench for the rtc register block
`timescale 1ns/100ps
module tb;
  localparam logic [15:0] CT = rtc_pkg::OFF_CTRL;
  localparam logic [15:0] NS = rtc_pkg::OFF_NS_HI;
  localparam logic [15:0] SC = rtc_pkg::OFF_SEC_HI;
  localparam logic [15:0] RH = rtc_pkg::OFF_RATE_HI;
  localparam logic [15:0] TD = rtc_pkg::OFF_TDUR_HI;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic [31:0] o_live_sec;
  logic [31:0] o_live_ns;
  logic [2:0] o_live_phase;
  int num_errors = 0;
  int checks = 0;
  int t;
  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;
  rtc_core rtc_core_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_live_sec(o_live_sec), .o_live_ns(o_live_ns),
    .o_live_phase(o_live_phase));
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // one-cycle write, effects settled on return
  task automatic wr(input logic [15:0] a, d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  // both words of a 32-bit value, high word first
  task automatic wr32(input logic [15:0] a, input logic [31:0] v);
    wr(a, v[31:16]);
    wr(a + 16'h0002, v[15:0]);
  endtask : wr32
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk($sformatf("read %h", a), {16'h0, e}, {16'h0, o_rdata});
  endtask : rd
  // follow n ticks from zero; the first m carry a half-ns correction
  task automatic run(input int n, m, input bit up);
    logic [31:0] e;
    int c;
    e = 32'h0;
    for (int k = 1; k <= n; k++) begin
      t = 0;
      while (o_live_ns === e && t < 20) begin
        @(posedge i_clk);
        #1 t++;
      end
      if (t == 20) begin
        num_errors++;
        conclude();
      end
      c = k < m ? k : m;
      e = 40 * k + (up ? c / 2 : -((c + 1) / 2));
      chk("tick ns", e, o_live_ns);
    end
  endtask : run
  // verdict
  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    // reset values, then each word keeps what it was given
    for (int i = 0; i < 9; i++) rd(16'(16'h0502 + 2 * i), 16'h0);
    rd(16'h0600, 16'h0000);
    for (int i = 0; i < 8; i++) wr(16'(NS + 2 * i), 16'((i + 1) * 257));
    for (int i = 0; i < 8; i++) rd(16'(NS + 2 * i), 16'((i + 1) * 257));
    wr(rtc_pkg::OFF_PHASE, 16'h0004);
    rd(rtc_pkg::OFF_PHASE, 16'h0004);
    // load near the end of a second and watch the carry
    wr32(NS, 32'h3B9A_C9B0);
    wr32(SC, 32'h0001_FFFF);
    wr32(RH, 32'h0);
    wr(CT, 16'h000A);
    chk("load ns", 32'h3B9A_C9B0, o_live_ns);
    chk("load sec", 32'h0001_FFFF, o_live_sec);
    chk("load phase", 32'h4, 32'(o_live_phase));
    t = 0;
    while (o_live_sec === 32'h0001_FFFF && t < 40) begin
      @(posedge i_clk);
      #1 t++;
    end
    // a carry that never comes ends the run
    if (t == 40) begin
      num_errors++;
      conclude();
    end
    chk("wrap sec", 32'h0002_0000, o_live_sec);
    chk("wrap ns", 32'h0, o_live_ns);
    // snapshot of a stopped clock, then step both ways
    wr32(NS, 32'h1DCD_6500);
    wr32(SC, 32'h10);
    wr(CT, 16'h0008);
    wr32(NS, 32'h0);
    wr32(SC, 32'h0);
    wr(CT, 16'h0010);
    rd(NS, 16'h1DCD);
    rd(NS + 16'h2, 16'h6500);
    rd(SC + 16'h2, 16'h0010);
    rd(CT, 16'h0000);
    wr32(NS, 32'h64);
    wr32(SC, 32'h1);
    wr(CT, 16'h0060);
    chk("step up ns", 32'h1DCD_6564, o_live_ns);
    chk("step up sec", 32'h11, o_live_sec);
    wr(CT, 16'h0040);
    chk("step down ns", 32'h1DCD_6500, o_live_ns);
    chk("step down sec", 32'h10, o_live_sec);
    // continuous half-ns correction, subtract then add
    for (int d = 0; d < 2; d++) begin
      wr(RH, d ? 16'hA000 : 16'h2000);
      wr(CT, 16'h0001);
      wr(CT, 16'h0006);
      run(6, 6, d[0]);
    end
    // temporary correction for two ticks only
    wr(CT, 16'h0001);
    wr32(TD, 32'h2);
    wr(RH, 16'hE000);
    wr(CT, 16'h0002);
    run(5, 2, 1'b1);
    rd(RH, 16'hA000);
    rd(TD + 16'h2, 16'h0000);
    // clearing the temporary bit before the clock runs
    wr(CT, 16'h0001);
    wr32(TD, 32'h64);
    wr(RH, 16'hE000);
    wr(RH, 16'hA000);
    wr(CT, 16'h0002);
    run(3, 0, 1'b1);
    rd(TD + 16'h2, 16'h0064);
    // reset again in mid-run
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    rd(RH, 16'h0000);
    chk("reset ns", 32'h0, o_live_ns);
    chk("reset sec", 32'h0, o_live_sec);
    conclude();
  end
endmodule : tb
